/* logic/ucf_pkg.sv */
// Purpose: shared constants and types of the serial control block
// Assumes: 32-bit AXI4-Lite register port, one system clock
// Notes: register byte address is four times the register index
`default_nettype none
package ucf_pkg;
   // register indexes; byte address = index * 4
   localparam logic [7:0] UCF_IDX_CTRL_A = 8'hc0;
   localparam logic [7:0] UCF_IDX_CTRL_B = 8'hc1;
   localparam logic [7:0] UCF_IDX_CTRL_C = 8'hc2;
   localparam logic [7:0] UCF_IDX_BAUD = 8'hc4;
   localparam logic [7:0] UCF_IDX_DATA = 8'hc6;
   localparam int UCF_IDX_LSB = 2;
   localparam int UCF_IDX_MSB = 9;

   // control A fields
   localparam int UCF_A_RXC = 7;
   localparam int UCF_A_TXC = 6;
   localparam int UCF_A_UDRE = 5;
   localparam int UCF_A_FE = 4;
   localparam int UCF_A_DOR = 3;
   localparam int UCF_A_UPE = 2;
   localparam int UCF_A_DBL = 1;
   localparam int UCF_A_AFE = 0;
   // control B fields
   localparam int UCF_B_RXIE = 7;
   localparam int UCF_B_TXIE = 6;
   localparam int UCF_B_EMIE = 5;
   localparam int UCF_B_RXEN = 4;
   localparam int UCF_B_TXEN = 3;
   localparam int UCF_B_CSH = 2;
   localparam int UCF_B_RX9 = 1;
   localparam int UCF_B_TX9 = 0;
   // control C fields
   localparam int UCF_C_PAR_HI = 5;
   localparam int UCF_C_PAR_LO = 4;
   localparam int UCF_C_STOP = 3;
   localparam int UCF_C_CSL_HI = 2;
   localparam int UCF_C_CSL_LO = 1;

   localparam logic [1:0] UCF_CSL_RST = 2'h3;
   localparam logic [11:0] UCF_BAUD_RST = 12'h019;
   localparam logic [1:0] UCF_PAR_OFF = 2'h0;
   localparam logic [1:0] UCF_PAR_EVEN = 2'h2;
   localparam logic [1:0] UCF_PAR_ODD = 2'h3;
   localparam logic [4:0] UCF_SPB_NORMAL = 5'h10;
   localparam logic [4:0] UCF_SPB_DOUBLE = 5'h08;
   localparam logic [3:0] UCF_BITS_9 = 4'h9;
   localparam logic [3:0] UCF_BITS_8 = 4'h8;
   localparam logic [3:0] UCF_BITS_5 = 4'h5;
   localparam logic [2:0] UCF_CS_9 = 3'h7;
   localparam logic [1:0] UCF_RESP_OKAY = 2'h0;
   localparam logic [1:0] UCF_RESP_SLVERR = 2'h2;

   typedef enum logic [4:0] {
      UCF_RX_IDLE = 5'h01,
      UCF_RX_START = 5'h02,
      UCF_RX_DATA = 5'h04,
      UCF_RX_PAR = 5'h08,
      UCF_RX_STOP = 5'h10
   } ucf_rx_state_t;

   typedef enum logic [5:0] {
      UCF_TX_IDLE = 6'h01,
      UCF_TX_START = 6'h02,
      UCF_TX_DATA = 6'h04,
      UCF_TX_PAR = 6'h08,
      UCF_TX_STOP1 = 6'h10,
      UCF_TX_STOP2 = 6'h20
   } ucf_tx_state_t;

   typedef struct packed {
      logic double_speed;
      logic address_filter_enable;
      logic rx_done_irq_enable;
      logic tx_done_irq_enable;
      logic tx_empty_irq_enable;
      logic receiver_enable;
      logic transmitter_enable;
      logic char_size_high;
      logic tx_ninth_bit;
      logic [1:0] parity_mode;
      logic stop_select;
      logic [1:0] char_size_low;
      logic [11:0] baud_div;
   } ucf_cfg_t;

   typedef struct packed {
      logic [8:0] data;
      logic framing_error_flag;
      logic parity_error_flag;
   } ucf_rx_entry_t;
endpackage
`default_nettype wire

/* logic/ucf_top.sv */
// Purpose: control, frame format and serial engine of an async transceiver
// Assumes: SERIAL_IN_PIN is asynchronous; GLOBAL_IRQ_ENABLE is on CLK
// Notes: one-entry receive buffer
`default_nettype none
module ucf_top
   import ucf_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter logic [11:0] BAUD_DIV_RST = UCF_BAUD_RST
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic SERIAL_IN_PIN,
   output logic SERIAL_IN_OWNED,
   output logic SERIAL_OUT_PIN,
   output logic SERIAL_OUT_OE,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic TX_DONE_IRQ_ACK,
   output logic IRQ_RX_DONE,
   output logic IRQ_TX_DONE,
   output logic IRQ_TX_EMPTY
);

   typedef struct packed {
      logic sin_meta;
      logic sin;
      logic [11:0] baud_cnt;
      ucf_cfg_t cfg;
      ucf_rx_state_t rx_st;
      logic [4:0] rx_cnt;
      logic [3:0] rx_idx;
      logic [8:0] rx_shift;
      logic rx_par;
      logic rx_full;
      ucf_rx_entry_t rx_buf;
      logic overrun_flag;
      ucf_tx_state_t tx_st;
      logic [4:0] tx_cnt;
      logic [3:0] tx_idx;
      logic [8:0] tx_shift;
      logic [8:0] tx_buf;
      logic tx_buf_full;
      logic tx_active;
      logic tx_complete_flag;
      logic tx_out;
      logic irq_rx;
      logic irq_tx;
      logic irq_empty;
      logic awready;
      logic wready;
      logic [7:0] aw_idx;
      logic aw_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ucf_state_t;

   ucf_state_t q_q;
   ucf_state_t q_d;

   // data bits per character; reserved codes fall back to eight bits
   function automatic logic [3:0] char_bits(input logic [2:0] code);
      if (code == UCF_CS_9) begin
         return UCF_BITS_9;
      end else if (code[2]) begin
         return UCF_BITS_8;
      end else begin
         return UCF_BITS_5 + {2'h0, code[1:0]};
      end
   endfunction

   // parity over the low n bits; odd mode inverts the even result
   function automatic logic parity_of(input logic [8:0] v,
                                      input logic [3:0] n,
                                      input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(n)) begin
            p = p ^ v[i];
         end
      end
      return p;
   endfunction

   // low address bits select the register; must be word aligned
   function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
      return a[UCF_IDX_MSB:UCF_IDX_LSB];
   endfunction

   function automatic logic idx_known(input logic [7:0] i);
      return (i == UCF_IDX_CTRL_A) || (i == UCF_IDX_CTRL_B) ||
             (i == UCF_IDX_CTRL_C) || (i == UCF_IDX_BAUD) ||
             (i == UCF_IDX_DATA);
   endfunction

   always_comb begin
      logic tick;
      logic [4:0] spb;
      logic [4:0] half;
      logic [3:0] nbits;
      logic par_on;
      logic par_odd;
      logic rx_bit_end;
      logic tx_bit_end;
      logic frame_type;
      logic [7:0] ridx;
      logic [7:0] reg_a;
      logic [7:0] reg_b;
      logic [7:0] reg_c;
      logic do_write;
      logic txc_set;
      tick = 1'b0;
      spb = '0;
      half = '0;
      nbits = '0;
      par_on = 1'b0;
      par_odd = 1'b0;
      rx_bit_end = 1'b0;
      tx_bit_end = 1'b0;
      frame_type = 1'b0;
      ridx = '0;
      reg_a = '0;
      reg_b = '0;
      reg_c = '0;
      do_write = 1'b0;
      txc_set = 1'b0;
      q_d = q_q;

      // input pin passes two flops before anything reads it
      q_d.sin_meta = SERIAL_IN_PIN;
      q_d.sin = q_q.sin_meta;

      tick = (q_q.baud_cnt == '0);
      q_d.baud_cnt = tick ? q_q.cfg.baud_div : q_q.baud_cnt - 12'h001;
      spb = q_q.cfg.double_speed ? UCF_SPB_DOUBLE : UCF_SPB_NORMAL;
      half = spb >> 1;
      nbits = char_bits({q_q.cfg.char_size_high,
                         q_q.cfg.char_size_low});
      // reserved code 01 runs without parity
      par_on = q_q.cfg.parity_mode[1];
      par_odd = (q_q.cfg.parity_mode == UCF_PAR_ODD);

      // receiver
      rx_bit_end = tick && (q_q.rx_cnt == spb - 5'h01);
      if (tick) begin
         q_d.rx_cnt = rx_bit_end ? 5'h00 : q_q.rx_cnt + 5'h01;
      end
      case (q_q.rx_st)
         UCF_RX_IDLE: begin
            if (q_q.cfg.receiver_enable && !q_q.sin) begin
               q_d.rx_st = UCF_RX_START;
               q_d.rx_cnt = '0;
            end
         end
         UCF_RX_START: begin
            // glitches under half a bit are dropped
            if (tick && q_q.rx_cnt == half - 5'h01) begin
               q_d.rx_cnt = '0;
               q_d.rx_idx = '0;
               q_d.rx_shift = '0;
               q_d.rx_st = q_q.sin ? UCF_RX_IDLE : UCF_RX_DATA;
            end
         end
         UCF_RX_DATA: begin
            if (rx_bit_end) begin
               q_d.rx_shift[q_q.rx_idx] = q_q.sin;
               q_d.rx_idx = q_q.rx_idx + 4'h1;
               if (q_q.rx_idx == nbits - 4'h1) begin
                  q_d.rx_st = par_on ? UCF_RX_PAR : UCF_RX_STOP;
               end
            end
         end
         UCF_RX_PAR: begin
            if (rx_bit_end) begin
               q_d.rx_par = q_q.sin;
               q_d.rx_st = UCF_RX_STOP;
            end
         end
         UCF_RX_STOP: begin
            // only the first stop is checked, whatever stop_select says
            if (rx_bit_end) begin
               q_d.rx_st = UCF_RX_IDLE;
               frame_type = (nbits == UCF_BITS_9) ? q_q.rx_shift[8]
                                                  : q_q.sin;
               if (q_q.cfg.address_filter_enable && !frame_type) begin
                  q_d.rx_st = UCF_RX_IDLE;
               end else if (q_q.rx_full) begin
                  q_d.overrun_flag = 1'b1;
               end else begin
                  q_d.rx_full = 1'b1;
                  q_d.rx_buf.data = q_q.rx_shift;
                  q_d.rx_buf.framing_error_flag = !q_q.sin;
                  q_d.rx_buf.parity_error_flag = par_on &&
                     (parity_of(q_q.rx_shift, nbits, par_odd) !=
                      q_q.rx_par);
               end
            end
         end
         default: begin
            q_d.rx_st = UCF_RX_IDLE;
         end
      endcase

      // transmitter
      // nothing here looks at address_filter_enable
      tx_bit_end = tick && (q_q.tx_cnt == spb - 5'h01);
      if (tick) begin
         q_d.tx_cnt = tx_bit_end ? 5'h00 : q_q.tx_cnt + 5'h01;
      end
      case (q_q.tx_st)
         UCF_TX_IDLE: begin
            q_d.tx_out = 1'b1;
            if (q_q.tx_active && q_q.tx_buf_full) begin
               q_d.tx_shift = q_q.tx_buf;
               q_d.tx_buf_full = 1'b0;
               q_d.tx_st = UCF_TX_START;
               q_d.tx_cnt = '0;
               q_d.tx_idx = '0;
               q_d.tx_out = 1'b0;
            end
         end
         UCF_TX_START: begin
            if (tx_bit_end) begin
               q_d.tx_st = UCF_TX_DATA;
               q_d.tx_out = q_q.tx_shift[0];
               q_d.tx_idx = 4'h1;
            end
         end
         UCF_TX_DATA: begin
            if (tx_bit_end) begin
               q_d.tx_idx = q_q.tx_idx + 4'h1;
               if (q_q.tx_idx == nbits) begin
                  q_d.tx_st = par_on ? UCF_TX_PAR : UCF_TX_STOP1;
                  q_d.tx_out = par_on ?
                     parity_of(q_q.tx_shift, nbits, par_odd)
                     : 1'b1;
               end else begin
                  q_d.tx_out = q_q.tx_shift[q_q.tx_idx];
               end
            end
         end
         UCF_TX_PAR: begin
            if (tx_bit_end) begin
               q_d.tx_st = UCF_TX_STOP1;
               q_d.tx_out = 1'b1;
            end
         end
         UCF_TX_STOP1: begin
            if (tx_bit_end) begin
               q_d.tx_st = q_q.cfg.stop_select ? UCF_TX_STOP2
                                               : UCF_TX_IDLE;
               txc_set = !q_q.cfg.stop_select && !q_q.tx_buf_full;
            end
         end
         UCF_TX_STOP2: begin
            if (tx_bit_end) begin
               q_d.tx_st = UCF_TX_IDLE;
               txc_set = !q_q.tx_buf_full;
            end
         end
         default: begin
            q_d.tx_st = UCF_TX_IDLE;
         end
      endcase

      // clearing the enable only lands once shifter and buffer drain
      if (q_q.cfg.transmitter_enable) begin
         q_d.tx_active = 1'b1;
      end else if (q_q.tx_st == UCF_TX_IDLE && !q_q.tx_buf_full) begin
         q_d.tx_active = 1'b0;
      end

      // register reads
      reg_a[UCF_A_RXC] = q_q.rx_full;
      reg_a[UCF_A_TXC] = q_q.tx_complete_flag;
      reg_a[UCF_A_UDRE] = !q_q.tx_buf_full;
      reg_a[UCF_A_FE] = q_q.rx_buf.framing_error_flag;
      reg_a[UCF_A_DOR] = q_q.overrun_flag;
      reg_a[UCF_A_UPE] = q_q.rx_buf.parity_error_flag;
      reg_a[UCF_A_DBL] = q_q.cfg.double_speed;
      reg_a[UCF_A_AFE] = q_q.cfg.address_filter_enable;
      reg_b[UCF_B_RXIE] = q_q.cfg.rx_done_irq_enable;
      reg_b[UCF_B_TXIE] = q_q.cfg.tx_done_irq_enable;
      reg_b[UCF_B_EMIE] = q_q.cfg.tx_empty_irq_enable;
      reg_b[UCF_B_RXEN] = q_q.cfg.receiver_enable;
      reg_b[UCF_B_TXEN] = q_q.cfg.transmitter_enable;
      reg_b[UCF_B_CSH] = q_q.cfg.char_size_high;
      reg_b[UCF_B_RX9] = q_q.rx_buf.data[8];
      reg_b[UCF_B_TX9] = q_q.cfg.tx_ninth_bit;
      reg_c = '0;
      reg_c[UCF_C_PAR_HI:UCF_C_PAR_LO] = q_q.cfg.parity_mode;
      reg_c[UCF_C_STOP] = q_q.cfg.stop_select;
      reg_c[UCF_C_CSL_HI:UCF_C_CSL_LO] = q_q.cfg.char_size_low;

      if (q_q.rvalid && S_AXI_RREADY) begin
         q_d.rvalid = 1'b0;
         q_d.arready = 1'b1;
      end
      if (q_q.arready && S_AXI_ARVALID) begin
         ridx = reg_idx(S_AXI_ARADDR);
         q_d.arready = 1'b0;
         q_d.rvalid = 1'b1;
         q_d.rdata = '0;
         q_d.rresp = idx_known(ridx) ? UCF_RESP_OKAY : UCF_RESP_SLVERR;
         case (ridx)
            UCF_IDX_CTRL_A: q_d.rdata[7:0] = reg_a;
            UCF_IDX_CTRL_B: q_d.rdata[7:0] = reg_b;
            UCF_IDX_CTRL_C: q_d.rdata[7:0] = reg_c;
            UCF_IDX_BAUD: q_d.rdata[11:0] = q_q.cfg.baud_div;
            UCF_IDX_DATA: begin
               // reading the data port consumes the character
               q_d.rdata[7:0] = q_q.rx_buf.data[7:0];
               q_d.rx_full = 1'b0;
               q_d.overrun_flag = 1'b0;
               q_d.rx_buf.framing_error_flag = 1'b0;
               q_d.rx_buf.parity_error_flag = 1'b0;
            end
            default: q_d.rdata = '0;
         endcase
      end

      // register writes
      if (q_q.awready && S_AXI_AWVALID) begin
         q_d.awready = 1'b0;
         q_d.aw_idx = reg_idx(S_AXI_AWADDR);
         q_d.aw_ok = idx_known(reg_idx(S_AXI_AWADDR));
      end
      if (q_q.wready && S_AXI_WVALID) begin
         q_d.wready = 1'b0;
         q_d.wdata = S_AXI_WDATA;
         q_d.wstrb = S_AXI_WSTRB;
      end
      do_write = !q_q.awready && !q_q.wready && !q_q.bvalid;
      if (do_write) begin
         q_d.bvalid = 1'b1;
         q_d.bresp = q_q.aw_ok ? UCF_RESP_OKAY : UCF_RESP_SLVERR;
      end
      if (q_q.bvalid && S_AXI_BREADY) begin
         q_d.bvalid = 1'b0;
         q_d.awready = 1'b1;
         q_d.wready = 1'b1;
      end
      if (do_write && q_q.wstrb[0]) begin
         case (q_q.aw_idx)
            UCF_IDX_CTRL_A: begin
               q_d.cfg.double_speed = q_q.wdata[UCF_A_DBL];
               q_d.cfg.address_filter_enable = q_q.wdata[UCF_A_AFE];
            end
            UCF_IDX_CTRL_B: begin
               q_d.cfg.rx_done_irq_enable = q_q.wdata[UCF_B_RXIE];
               q_d.cfg.tx_done_irq_enable = q_q.wdata[UCF_B_TXIE];
               q_d.cfg.tx_empty_irq_enable = q_q.wdata[UCF_B_EMIE];
               q_d.cfg.receiver_enable = q_q.wdata[UCF_B_RXEN];
               q_d.cfg.transmitter_enable = q_q.wdata[UCF_B_TXEN];
               q_d.cfg.char_size_high = q_q.wdata[UCF_B_CSH];
               q_d.cfg.tx_ninth_bit = q_q.wdata[UCF_B_TX9];
            end
            UCF_IDX_CTRL_C: begin
               q_d.cfg.parity_mode =
                  q_q.wdata[UCF_C_PAR_HI:UCF_C_PAR_LO];
               q_d.cfg.stop_select = q_q.wdata[UCF_C_STOP];
               q_d.cfg.char_size_low =
                  q_q.wdata[UCF_C_CSL_HI:UCF_C_CSL_LO];
            end
            UCF_IDX_DATA: begin
               // a write while the buffer is full is dropped
               if (!q_q.tx_buf_full) begin
                  q_d.tx_buf = {q_q.cfg.tx_ninth_bit,
                                q_q.wdata[7:0]};
                  q_d.tx_buf_full = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      if (do_write && q_q.wstrb[0] && q_q.aw_idx == UCF_IDX_BAUD) begin
         q_d.cfg.baud_div[7:0] = q_q.wdata[7:0];
         if (q_q.wstrb[1]) begin
            q_d.cfg.baud_div = q_q.wdata[11:0];
         end
      end

      // completion set wins over a same-cycle ack or write-one clear
      if ((do_write && q_q.wstrb[0] && q_q.aw_idx == UCF_IDX_CTRL_A &&
           q_q.wdata[UCF_A_TXC]) || TX_DONE_IRQ_ACK) begin
         q_d.tx_complete_flag = 1'b0;
      end
      if (txc_set) begin
         q_d.tx_complete_flag = 1'b1;
      end

      // a disabled receiver holds nothing and reports no errors
      if (!q_q.cfg.receiver_enable) begin
         q_d.rx_st = UCF_RX_IDLE;
         q_d.rx_full = 1'b0;
         q_d.overrun_flag = 1'b0;
         q_d.rx_buf.framing_error_flag = 1'b0;
         q_d.rx_buf.parity_error_flag = 1'b0;
      end

      q_d.irq_rx = q_q.cfg.rx_done_irq_enable && GLOBAL_IRQ_ENABLE &&
                   q_q.rx_full;
      q_d.irq_tx = q_q.cfg.tx_done_irq_enable && GLOBAL_IRQ_ENABLE &&
                   q_q.tx_complete_flag;
      q_d.irq_empty = q_q.cfg.tx_empty_irq_enable && GLOBAL_IRQ_ENABLE &&
                      !q_q.tx_buf_full;

      if (RST) begin
         q_d = '0;
         q_d.sin_meta = 1'b1;
         q_d.sin = 1'b1;
         q_d.cfg.char_size_low = UCF_CSL_RST;
         q_d.cfg.baud_div = BAUD_DIV_RST;
         q_d.rx_st = UCF_RX_IDLE;
         q_d.tx_st = UCF_TX_IDLE;
         q_d.tx_out = 1'b1;
         q_d.awready = 1'b1;
         q_d.wready = 1'b1;
         q_d.arready = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      q_q <= q_d;
   end

   assign S_AXI_AWREADY = q_q.awready;
   assign S_AXI_WREADY = q_q.wready;
   assign S_AXI_BVALID = q_q.bvalid;
   assign S_AXI_BRESP = q_q.bresp;
   assign S_AXI_ARREADY = q_q.arready;
   assign S_AXI_RVALID = q_q.rvalid;
   assign S_AXI_RDATA = q_q.rdata;
   assign S_AXI_RRESP = q_q.rresp;
   assign SERIAL_IN_OWNED = q_q.cfg.receiver_enable;
   // pin stays with the transmitter until the deferred disable lands
   assign SERIAL_OUT_OE = q_q.tx_active;
   assign SERIAL_OUT_PIN = q_q.tx_out;
   assign IRQ_RX_DONE = q_q.irq_rx;
   assign IRQ_TX_DONE = q_q.irq_tx;
   assign IRQ_TX_EMPTY = q_q.irq_empty;

endmodule // ucf_top
`default_nettype wire

/* tb/ucf_top_properties.sv */
// Purpose: port-level checks of the serial control block
// Assumes: bound to ucf_top, one clock domain
// Notes: irq outputs follow last cycle's global enable
`default_nettype none
module ucf_props (
   input wire logic CLK,
   input wire logic RST,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic SERIAL_OUT_PIN,
   input wire logic SERIAL_OUT_OE,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic IRQ_RX_DONE,
   input wire logic IRQ_TX_DONE,
   input wire logic IRQ_TX_EMPTY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   property p_rx_irq; IRQ_RX_DONE |-> $past(GLOBAL_IRQ_ENABLE); endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("rx irq, global off");
   property p_tx_irq; IRQ_TX_DONE |-> $past(GLOBAL_IRQ_ENABLE); endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx irq, global off");
   property p_em_irq; IRQ_TX_EMPTY |-> $past(GLOBAL_IRQ_ENABLE); endproperty
   a_em_irq: assert property (p_em_irq) else $error("empty irq, global off");
   // a bit is at least 8 clocks
   property p_bit; $fell(SERIAL_OUT_PIN) |-> !SERIAL_OUT_PIN [*8]; endproperty
   a_bit: assert property (p_bit) else $error("short bit");
   property p_oe; $fell(SERIAL_OUT_PIN) |-> SERIAL_OUT_OE; endproperty
   a_oe: assert property (p_oe) else $error("low while released");
   property p_rel;
      $fell(SERIAL_OUT_OE) |-> SERIAL_OUT_PIN && $past(SERIAL_OUT_PIN, 8);
   endproperty
   a_rel: assert property (p_rel) else $error("released mid frame");
   property p_idle; !SERIAL_OUT_OE |-> SERIAL_OUT_PIN; endproperty
   a_idle: assert property (p_idle) else $error("released line not idle");
   property p_rsvd; S_AXI_RVALID |-> S_AXI_RDATA[31:12] == 20'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("upper read bits set");
   property p_rhold;
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule // ucf_props
bind ucf_top ucf_props i_ucf_props (.*);
`default_nettype wire

/* tb/ucf_partner.sv */
// Purpose: remote serial station, sends and samples frames
// Assumes: bit time given in clocks by the caller
// Notes: line rests high between frames, as line_out is driven high by this station
`default_nettype none
module ucf_partner (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial line_out = 1'b1;
   task automatic send(input logic [11:0] f, input int n, input int bt);
      int i;
      @(posedge clk);
      for (i = -1; i < n; i++) begin
         line_out <= (i < 0) ? 1'b0 : f[i];
         repeat (bt) @(posedge clk);
      end
      line_out <= 1'b1;
   endtask
   // bounded hunt for the start bit, then sample each bit mid-way
   task automatic recv(input int n, input int bt, output logic [11:0] f);
      int i;
      f = 12'h000;
      for (i = 0; i < 5000 && line_in !== 1'b0; i++) @(posedge clk);
      repeat (bt / 2) @(posedge clk);
      for (i = 0; i < n; i++) begin
         repeat (bt) @(posedge clk);
         f[i] = line_in;
      end
   endtask
endmodule // ucf_partner
`default_nettype wire

/* tb/test_ucf_top.sv */
// Purpose: self-checking bench of the serial control block
// Assumes: divisor register resets to 0, so a bit is 16 or 8 clocks
// Notes: random formats, seed 42
`default_nettype none
module test_ucf_top;
   import ucf_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
   logic S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
   logic GLOBAL_IRQ_ENABLE = 0, TX_DONE_IRQ_ACK = 0, SERIAL_IN_PIN;
   logic [11:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
   logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
   logic [3:0] S_AXI_WSTRB = 4'hf;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID;
   logic S_AXI_RVALID, SERIAL_IN_OWNED, SERIAL_OUT_PIN, SERIAL_OUT_OE;
   logic IRQ_RX_DONE, IRQ_TX_DONE, IRQ_TX_EMPTY;
   int failures = 0, num_checks = 0;
   always #12.5 CLK = ~CLK;
   ucf_top #(.BAUD_DIV_RST(12'h000)) i_ucf_top (.*);
   ucf_partner i_ucf_partner (.clk(CLK), .line_in(SERIAL_OUT_PIN),
      .line_out(SERIAL_IN_PIN));
   task automatic chk(input string s, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      int n;
      @(posedge CLK);
      S_AXI_AWADDR <= {2'h0, ix, 2'h0};
      S_AXI_WDATA <= {24'h0, d};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
         if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1 && n < 99);
      S_AXI_BREADY <= 1'b0;
      if (n >= 99) begin
         failures++;
         final_report;
      end
   endtask
   // rready rises with rvalid, one edge after arvalid, so the answer never waits
   task automatic rd(input logic [7:0] ix, output logic [31:0] d, r);
      int n;
      @(posedge CLK);
      S_AXI_ARADDR <= {2'h0, ix, 2'h0};
      S_AXI_ARVALID <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
         if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
         d = S_AXI_RDATA;
         r = {30'h0, S_AXI_RRESP};
         S_AXI_RREADY <= 1'b1;
      end while (!(S_AXI_RVALID === 1'b1 && S_AXI_RREADY) && n < 99);
      S_AXI_RREADY <= 1'b0;
      if (n >= 99) begin
         failures++;
         final_report;
      end
   endtask
   task automatic rchk(input logic [7:0] ix, m, e, input string s);
      logic [31:0] d, r;
      rd(ix, d, r);
      chk(s, d & {24'h0, m}, {24'h0, e});
   endtask
   function automatic logic [11:0] frm(input logic [8:0] d, input int nb,
      input logic [1:0] pm, input logic st, output int len);
      logic [11:0] f;
      logic p;
      f = 12'h000;
      p = pm[0];
      for (len = 0; len < nb; len++) begin
         f[len] = d[len];
         p ^= d[len];
      end
      if (pm[1]) begin
         f[len] = p;
         len++;
      end
      len = len + 1 + st;
      f[len - 1] = 1'b1;
      f[len - 1 - st] = 1'b1;
      return f;
   endfunction
   initial begin
      int i, nb, len, bt;
      logic [8:0] d;
      logic [2:0] cs;
      logic [1:0] pm;
      logic st, ds, af, em, bad, drop;
      logic [11:0] f, g;
      logic [31:0] v, r;
      void'($urandom(42));
      repeat (8) @(posedge CLK);
      RST <= 1'b0;
      rchk(UCF_IDX_CTRL_A, 8'hff, 8'h20, "ctrl_a reset");
      rchk(UCF_IDX_CTRL_B, 8'hff, 8'h00, "ctrl_b reset");
      rchk(UCF_IDX_CTRL_C, 8'hff, 8'h06, "ctrl_c reset");
      wr(UCF_IDX_CTRL_C, 8'hff);
      rchk(UCF_IDX_CTRL_C, 8'hff, 8'h3e, "ctrl_c reserved");
      rd(8'h10, v, r);
      chk("unmapped resp", r, {30'h0, UCF_RESP_SLVERR});
      for (i = 0; i < 16; i++) begin
         nb = (i % 8 < 2) ? 9 : 5 + $urandom % 4;
         cs = (nb == 9) ? UCF_CS_9 : 3'(nb - 5);
         pm = 2'($urandom);
         {st, ds, af, em} = 4'($urandom);
         d = 9'($urandom);
         if (i == 9) {af, d[8]} = 2'b10;
         GLOBAL_IRQ_ENABLE <= 1'($urandom);
         bt = ds ? 8 : 16;
         wr(UCF_IDX_CTRL_A, {6'h0, ds, af});
         wr(UCF_IDX_CTRL_C, {2'h0, pm, st, cs[1:0], 1'b0});
         wr(UCF_IDX_CTRL_B, {2'h2, em, 2'h3, cs[2], 1'b0, d[8]});
         if (i < 8) begin
            f = frm(d, nb, pm, st, len);
            fork
               i_ucf_partner.recv(len, bt, g);
               wr(UCF_IDX_DATA, d[7:0]);
            join
            chk("tx frame", g, f);
            chk("empty irq", IRQ_TX_EMPTY, em & GLOBAL_IRQ_ENABLE);
            repeat (bt) @(posedge CLK);
         end else begin
            bad = pm[1] & 1'($urandom);
            f = frm(d, nb, pm, 1'b0, len);
            f[nb] ^= bad;
            drop = af && nb == 9 && !d[8];
            i_ucf_partner.send(f, len, bt);
            repeat (2) @(posedge CLK);
            chk("rx irq", IRQ_RX_DONE, !drop & GLOBAL_IRQ_ENABLE);
            rchk(UCF_IDX_CTRL_A, 8'h84, {!drop, 4'h0, bad & !drop, 2'h0},
               "rx flags");
            if (!drop) begin
               rchk(UCF_IDX_CTRL_B, {6'h0, nb == 9, 1'b0},
                  {6'h0, d[8] && nb == 9, 1'b0}, "rx ninth");
               rchk(UCF_IDX_DATA, 8'hff,
                  (nb > 8) ? d[7:0] : d[7:0] & ~(8'hff << nb), "rx data");
            end
         end
      end
      GLOBAL_IRQ_ENABLE <= 1'b1;
      wr(UCF_IDX_CTRL_A, 8'h40);
      wr(UCF_IDX_CTRL_C, 8'h06);
      wr(UCF_IDX_CTRL_B, 8'h58);
      fork
         i_ucf_partner.recv(9, 16, g);
         begin
            wr(UCF_IDX_DATA, 8'ha5);
            wr(UCF_IDX_CTRL_B, 8'h50);
            chk("oe held", SERIAL_OUT_OE, 1);
         end
      join
      chk("late frame", g, 12'h1a5);
      repeat (16) @(posedge CLK);
      chk("oe released", SERIAL_OUT_OE, 0);
      chk("tx done irq", IRQ_TX_DONE, 1);
      wr(UCF_IDX_CTRL_A, 8'h40);
      rchk(UCF_IDX_CTRL_A, 8'h40, 8'h00, "tx done cleared");
      i_ucf_partner.send(12'h13c, 9, 16);
      chk("in owned", SERIAL_IN_OWNED, 1);
      wr(UCF_IDX_CTRL_B, 8'h00);
      chk("in released", SERIAL_IN_OWNED, 0);
      rchk(UCF_IDX_CTRL_A, 8'h9c, 8'h00, "rx flushed");
      final_report;
   end
endmodule // test_ucf_top
`default_nettype wire
